// [shared/otwp_defines.vh]
`ifndef OTWP_DEFINES_VH
`define OTWP_DEFINES_VH
// ==========================================================
// apb register map (byte addresses)
`define OTWP_AW          12
`define OTWP_ADDR_CMD    12'h000
`define OTWP_ADDR_STATE  12'h004
`define OTWP_ADDR_ISTAT  12'h008
`define OTWP_ADDR_IMASK  12'h00c
// ==========================================================
// command register fields: instruction byte then data byte
`define OTWP_CMD_ARR     15
`define OTWP_CMD_SD      14
`define OTWP_CMD_PROG    13
`define OTWP_CMD_ZERO    12
`define OTWP_CMD_OW      11
`define OTWP_CMD_DHI     7
`define OTWP_CMD_DLO     0
// read view of the command register
`define OTWP_RD_VHI      15
`define OTWP_RD_VLO      14
// ==========================================================
// state register fields
`define OTWP_ST_SD       0
`define OTWP_ST_OW       1
`define OTWP_ST_BUSY     2
`define OTWP_ST_USED0    3
`define OTWP_ST_USED1    4
`define OTWP_ST_LOCK     5
`define OTWP_ST_BOOT     6
// ==========================================================
// interrupt bits
`define OTWP_IRQ_W       4
`define OTWP_IRQ_OK      0
`define OTWP_IRQ_FAIL    1
`define OTWP_IRQ_REFUSE  2
`define OTWP_IRQ_BOOT    3
// ==========================================================
// values
`define OTWP_MIDSCALE    8'h80
`define OTWP_ZERO_CODE   8'h00
`define OTWP_TAPS        256
`define OTWP_V_READY     2'h0
`define OTWP_V_FAIL      2'h2
`define OTWP_V_OK        2'h3
// ==========================================================
// timing
`define OTWP_BURN_MS     400
`define OTWP_CLK_KHZ     20000
`define OTWP_CNT_W       24
`define OTWP_SENSE_CYC   24'h000004
`define OTWP_BOOT_CYC    2'h3
`endif

// [hw/otwp_fuse_ctrl.v]
`timescale 1ns/1ps
`include "otwp_defines.vh"
module otwp_fuse_ctrl #(
  parameter BURN_CYC = `OTWP_BURN_MS * `OTWP_CLK_KHZ
) (
  // clock and reset
  input  wire       core_clk_i,
  input  wire       rst_n_i,
  // program request
  input  wire       start_i,
  input  wire       sel_i,
  input  wire [7:0] data_i,
  // sensed fuse state, already synchronised
  input  wire       used0_i,
  input  wire       used1_i,
  input  wire [7:0] val0_i,
  input  wire [7:0] val1_i,
  // fuse drive and result
  output reg        blow_o,
  output reg        blow_sel_o,
  output reg  [7:0] blow_data_o,
  output wire       busy_o,
  output reg        ok_o,
  output reg        fail_o,
  output reg        refuse_o
);
  // ==========================================================
  // sequencer states
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_BURN  = 2'h1;
  localparam [1:0] ST_SENSE = 2'h2;
  localparam [`OTWP_CNT_W-1:0] BURN_N = BURN_CYC[`OTWP_CNT_W-1:0];

  reg [1:0]             state_q;   // sequencer state
  reg [`OTWP_CNT_W-1:0] cnt_q;     // phase timer
  wire                  used_sel;  // target array already blown
  wire                  dead_sel;  // first array disabled by second

  assign busy_o   = (state_q != ST_IDLE);
  assign used_sel = sel_i ? used1_i : used0_i;
  // blowing the second array first kills the first one for good
  assign dead_sel = !sel_i && used1_i;

  // ==========================================================
  // one attempt per array, then verify by reading fuses back
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q     <= ST_IDLE;
      cnt_q       <= {`OTWP_CNT_W{1'b0}};
      blow_o      <= 1'b0;
      blow_sel_o  <= 1'b0;
      blow_data_o <= 8'h00;
      ok_o        <= 1'b0;
      fail_o      <= 1'b0;
      refuse_o    <= 1'b0;
    end else begin
      ok_o     <= 1'b0;
      fail_o   <= 1'b0;
      refuse_o <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start_i && (used_sel || dead_sel)) begin
            refuse_o <= 1'b1;
          end else if (start_i) begin
            blow_o      <= 1'b1;
            blow_sel_o  <= sel_i;
            blow_data_o <= data_i;
            cnt_q       <= BURN_N;
            state_q     <= ST_BURN;
          end
        end
        ST_BURN: begin
          // fuse current flows for the whole burn window
          if (cnt_q == {{(`OTWP_CNT_W-1){1'b0}}, 1'b1}) begin
            blow_o  <= 1'b0;
            cnt_q   <= `OTWP_SENSE_CYC;
            state_q <= ST_SENSE;
          end else begin
            cnt_q <= cnt_q - {{(`OTWP_CNT_W-1){1'b0}}, 1'b1};
          end
        end
        ST_SENSE: begin
          // wait out the sense synchronisers before judging
          if (cnt_q == {`OTWP_CNT_W{1'b0}}) begin
            if (blow_sel_o ? (used1_i && val1_i == blow_data_o)
                           : (used0_i && val0_i == blow_data_o)) begin
              ok_o <= 1'b1;
            end else begin
              fail_o <= 1'b1;
            end
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - {{(`OTWP_CNT_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          state_q <= ST_IDLE;
          blow_o  <= 1'b0;
        end
      endcase
    end
  end
endmodule // otwp_fuse_ctrl

// [hw/otwp_top.v]
// Notes on behaviour
// - blank fuses: power-on wiper preset is midscale
// - programmed fuses: power-on preset is stored setting
// - program bit commits current wiper to fuses
// - each fuse array may be blown once
// - keep two readable programming validation bits
// - blown fuses load latches every power-on
// - latch code selects exactly one of 256 taps
// - code zero connects wiper to B end
// - each code step moves tap away from B
// - wiper-to-A span maximal at zero, falls
// - instruction byte fields, then one data byte
// - read gives wiper byte then validation byte
// - overwrite allows changes, clearing restores setting
// - shutdown opens A, wiper to B, keeps latch
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "otwp_defines.vh"
module otwp_top #(
  parameter BURN_CYC = `OTWP_BURN_MS * `OTWP_CLK_KHZ
) (
  // clock and reset
  input  wire                   core_clk_i,
  input  wire                   rst_n_i,
  // apb slave
  input  wire                   psel_i,
  input  wire                   penable_i,
  input  wire                   pwrite_i,
  input  wire [`OTWP_AW-1:0]    paddr_i,
  input  wire [31:0]            pwdata_i,
  output reg  [31:0]            prdata_o,
  output wire                   pready_o,
  output wire                   pslverr_o,
  // sensed fuse arrays, asynchronous
  input  wire                   fuse0_used_i,
  input  wire [7:0]             fuse0_val_i,
  input  wire                   fuse1_used_i,
  input  wire [7:0]             fuse1_val_i,
  // fuse burn drive
  output wire                   fuse_blow_o,
  output wire                   fuse_blow_sel_o,
  output wire [7:0]             fuse_blow_data_o,
  // resistor ladder switches
  output reg  [`OTWP_TAPS-1:0]  tap_sel_o,
  output reg  [`OTWP_TAPS-1:0]  seg_wb_o,
  output reg  [`OTWP_TAPS-1:0]  seg_wa_o,
  output reg                    a_open_o,
  // interrupt
  output wire                   irq_o
);
  // ==========================================================
  // decode helpers
  // true when the code selects tap idx
  function hit;
    input [7:0] code;
    input [8:0] idx;
    begin
      hit = ({1'b0, code} == idx);
    end
  endfunction

  // true when segment idx lies below the wiper
  function below;
    input [7:0] code;
    input [8:0] idx;
    begin
      below = (idx < {1'b0, code});
    end
  endfunction

  // ==========================================================
  // fuse sense synchroniser
  reg  [17:0] sync1_q;    // first stage, read only by stage two
  reg  [17:0] sync2_q;    // safe copy
  wire        used0_s;    // first array blown
  wire        used1_s;    // second array blown
  wire [7:0]  val0_s;     // first array contents
  wire [7:0]  val1_s;     // second array contents

  // fuse lines settle long after power-up, so treat them as async
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= 18'h00000;
      sync2_q <= 18'h00000;
    end else begin
      sync1_q <= {fuse1_used_i, fuse1_val_i, fuse0_used_i, fuse0_val_i};
      sync2_q <= sync1_q;
    end
  end

  assign val0_s  = sync2_q[7:0];
  assign used0_s = sync2_q[8];
  assign val1_s  = sync2_q[16:9];
  assign used1_s = sync2_q[17];

  // ==========================================================
  // apb decode
  wire access;   // access phase of any transfer
  wire wr_en;    // write takes effect now
  wire mapped;   // address hits a register
  wire hit_cmd;  // command register
  wire hit_st;   // state register
  wire hit_is;   // interrupt status
  wire hit_im;   // interrupt mask

  assign hit_cmd   = (paddr_i == `OTWP_ADDR_CMD);
  assign hit_st    = (paddr_i == `OTWP_ADDR_STATE);
  assign hit_is    = (paddr_i == `OTWP_ADDR_ISTAT);
  assign hit_im    = (paddr_i == `OTWP_ADDR_IMASK);
  assign mapped    = hit_cmd | hit_st | hit_is | hit_im;
  assign access    = psel_i & penable_i;
  // no wait states: every access completes in its first cycle
  assign pready_o  = 1'b1;
  assign pslverr_o = access & ~mapped;
  assign wr_en     = access & pwrite_i & mapped;

  // ==========================================================
  // control state
  reg  [7:0] latch_q;    // wiper latch
  reg  [7:0] saved_q;    // setting held across overwrite
  reg        sd_q;       // shutdown bit
  reg        ow_q;       // overwrite bit
  reg  [1:0] valid_q;    // validation pair
  reg  [1:0] boot_q;     // power-on preset delay
  reg        booted_q;   // preset has been loaded
  reg        prog_go_q;  // one-cycle program start
  wire       busy;       // fuse sequencer running
  wire       prog_ok;    // burn verified
  wire       prog_fail;  // burn did not verify
  wire       prog_ref;   // burn refused
  wire       any_used;   // some array is blown
  wire       locked;     // writes blocked by blown fuses
  wire [7:0] preset;     // power-on preset code
  wire       cmd_wr;     // command frame written
  wire       cmd_bad;    // frame refused
  wire [7:0] ins;        // instruction byte
  wire [7:0] dat;        // data byte

  assign any_used = used0_s | used1_s;
  assign locked   = any_used & ~ow_q;
  // the later array wins since blowing it disables the earlier one
  assign preset   = used1_s ? val1_s :
                    used0_s ? val0_s : `OTWP_MIDSCALE;
  assign ins      = pwdata_i[`OTWP_CMD_ARR:`OTWP_CMD_OW-3];
  assign dat      = pwdata_i[`OTWP_CMD_DHI:`OTWP_CMD_DLO];
  assign cmd_wr   = wr_en & hit_cmd;
  // the fourth field must be zero; no command during boot or a burn
  assign cmd_bad  = cmd_wr & (pwdata_i[`OTWP_CMD_ZERO] | busy | ~booted_q);

  // ==========================================================
  // boot delay lets the sense synchroniser fill before preset
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boot_q   <= 2'h0;
      booted_q <= 1'b0;
    end else if (!booted_q) begin
      if (boot_q == `OTWP_BOOT_CYC) begin
        booted_q <= 1'b1;
      end else begin
        boot_q <= boot_q + 2'h1;
      end
    end
  end

  // ==========================================================
  // wiper latch, shutdown, overwrite and program launch
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_q   <= `OTWP_MIDSCALE;
      saved_q   <= `OTWP_MIDSCALE;
      sd_q      <= 1'b0;
      ow_q      <= 1'b0;
      prog_go_q <= 1'b0;
    end else begin
      prog_go_q <= 1'b0;
      if (!booted_q && boot_q == `OTWP_BOOT_CYC) begin
        // the later blown array, or midscale when both are blank, reaches the wiper at each power-on
        latch_q <= preset;
        saved_q <= preset;
      end else if (cmd_wr && !cmd_bad) begin
        sd_q <= ins[7-(`OTWP_CMD_ARR-`OTWP_CMD_SD)];
        ow_q <= ins[7-(`OTWP_CMD_ARR-`OTWP_CMD_OW)];
        if (pwdata_i[`OTWP_CMD_PROG]) begin
          // data byte ignored: the present latch is what gets burnt
          prog_go_q <= 1'b1;
        end else if (pwdata_i[`OTWP_CMD_OW]) begin
          if (!ow_q) begin
            saved_q <= latch_q;
          end
          latch_q <= dat;
        end else if (ow_q) begin
          // leaving overwrite puts back the setting from before it
          latch_q <= saved_q;
        end else if (!locked) begin
          // shutdown does not stop the latch from taking data
          latch_q <= dat;
          saved_q <= dat;
        end
      end
    end
  end

  // ==========================================================
  // fuse burn sequencer
  otwp_fuse_ctrl #(
    .BURN_CYC (BURN_CYC)
  ) u_fuse (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .start_i     (prog_go_q),
    .sel_i       (ins[7]),
    .data_i      (latch_q),
    .used0_i     (used0_s),
    .used1_i     (used1_s),
    .val0_i      (val0_s),
    .val1_i      (val1_s),
    .blow_o      (fuse_blow_o),
    .blow_sel_o  (fuse_blow_sel_o),
    .blow_data_o (fuse_blow_data_o),
    .busy_o      (busy),
    .ok_o        (prog_ok),
    .fail_o      (prog_fail),
    .refuse_o    (prog_ref)
  );

  // ==========================================================
  // validation bits: ready, failed or programmed
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valid_q <= `OTWP_V_READY;
    end else if (!booted_q && boot_q == `OTWP_BOOT_CYC) begin
      // a failed burn is not remembered across power cycles
      valid_q <= any_used ? `OTWP_V_OK : `OTWP_V_READY;
    end else if (prog_ok) begin
      valid_q <= `OTWP_V_OK;
    end else if (prog_fail) begin
      valid_q <= `OTWP_V_FAIL;
    end
  end

  // ==========================================================
  // ladder decode, registered so switches never glitch
  wire [7:0] code_eff;  // code seen by the ladder

  // shutdown forces zero scale while the latch keeps its value
  assign code_eff = sd_q ? `OTWP_ZERO_CODE : latch_q;

  genvar g;
  generate
    for (g = 0; g < `OTWP_TAPS; g = g + 1) begin : g_tap
      always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          tap_sel_o[g] <= 1'b0;
          seg_wb_o[g]  <= 1'b0;
          seg_wa_o[g]  <= 1'b0;
        end else begin
          // tap 0 is the B terminal contact itself
          tap_sel_o[g] <= hit(code_eff, g[8:0]);
          seg_wb_o[g]  <= below(code_eff, g[8:0]);
          // segments above the wiper, 256 minus code of them
          seg_wa_o[g]  <= ~below(code_eff, g[8:0]);
        end
      end
    end
  endgenerate

  // terminal a floats during shutdown
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_open_o <= 1'b0;
    end else begin
      a_open_o <= sd_q;
    end
  end

  // ==========================================================
  // interrupts: sticky status, write one to clear, mask
  reg  [`OTWP_IRQ_W-1:0] istat_q;  // sticky events
  reg  [`OTWP_IRQ_W-1:0] imask_q;  // enables
  wire [`OTWP_IRQ_W-1:0] ev;       // events this cycle
  wire [`OTWP_IRQ_W-1:0] w1c;      // bits cleared this cycle

  assign ev[`OTWP_IRQ_OK]     = prog_ok;
  assign ev[`OTWP_IRQ_FAIL]   = prog_fail;
  assign ev[`OTWP_IRQ_REFUSE] = prog_ref | cmd_bad;
  assign ev[`OTWP_IRQ_BOOT]   = ~booted_q & (boot_q == `OTWP_BOOT_CYC);
  assign w1c = (wr_en & hit_is) ? pwdata_i[`OTWP_IRQ_W-1:0] : {`OTWP_IRQ_W{1'b0}};
  assign irq_o = |(istat_q & imask_q);

  // a new event beats a clear in the same cycle
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      istat_q <= {`OTWP_IRQ_W{1'b0}};
      imask_q <= {`OTWP_IRQ_W{1'b0}};
    end else begin
      istat_q <= (istat_q & ~w1c) | ev;
      if (wr_en && hit_im) begin
        imask_q <= pwdata_i[`OTWP_IRQ_W-1:0];
      end
    end
  end

  // ==========================================================
  // read data, captured in the setup cycle
  reg [31:0] rd_d;  // selected read word

  always @* begin
    rd_d = 32'h00000000;
    if (hit_cmd) begin
      rd_d[`OTWP_CMD_DHI:`OTWP_CMD_DLO] = latch_q;
      rd_d[`OTWP_RD_VHI:`OTWP_RD_VLO]   = valid_q;
    end else if (hit_st) begin
      rd_d[`OTWP_ST_SD]    = sd_q;
      rd_d[`OTWP_ST_OW]    = ow_q;
      rd_d[`OTWP_ST_BUSY]  = busy;
      rd_d[`OTWP_ST_USED0] = used0_s;
      rd_d[`OTWP_ST_USED1] = used1_s;
      rd_d[`OTWP_ST_LOCK]  = locked;
      rd_d[`OTWP_ST_BOOT]  = booted_q;
    end else if (hit_is) begin
      rd_d[`OTWP_IRQ_W-1:0] = istat_q;
    end else if (hit_im) begin
      rd_d[`OTWP_IRQ_W-1:0] = imask_q;
    end
  end

  // unmapped reads return zero
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h00000000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= rd_d;
    end
  end
endmodule // otwp_top

// [dv/otwp_top_assertions.sv]
`timescale 1ns/1ps
`include "otwp_defines.vh"
// ======================================================
// port checker for the wiper preset block
module otwp_chk #(
  parameter BURN_CYC = 20
) (
  // clock, reset and apb request
  input logic                  core_clk_i,
  input logic                  rst_n_i,
  input logic                  psel_i,
  input logic                  penable_i,
  input logic                  pwrite_i,
  input logic [`OTWP_AW-1:0]   paddr_i,
  input logic [31:0]           pwdata_i,
  input logic                  pslverr_o,
  // fuse burn and ladder
  input logic                  fuse_blow_o,
  input logic                  fuse_blow_sel_o,
  input logic [7:0]            fuse_blow_data_o,
  input logic [`OTWP_TAPS-1:0] tap_sel_o,
  input logic [`OTWP_TAPS-1:0] seg_wb_o,
  input logic [`OTWP_TAPS-1:0] seg_wa_o,
  input logic                  a_open_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [2:0]  up_q;            // cycles since release, saturating
  logic [31:0] burn_q = 32'h0;  // length of the running burn
  logic        blow_q = 1'b0;   // burn drive one cycle ago
  logic [1:0]  blown_q = 2'h0;  // arrays burnt; no reset, fuses outlive power-on
  // ladder is only defined once the preset has landed
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  // burn length and per-array history
  always_ff @(posedge core_clk_i) begin
    burn_q <= fuse_blow_o ? burn_q + 32'h1 : 32'h0;
    blow_q <= fuse_blow_o;
    if (fuse_blow_o && !blow_q) blown_q[fuse_blow_sel_o] <= 1'b1;
  end
  // an accepted command write once booted
  sequence s_cmd_wr;
    psel_i && penable_i && pwrite_i && paddr_i == `OTWP_ADDR_CMD && !pwdata_i[12] && up_q == 3'h7;
  endsequence
  property p_ow_load;
    logic [7:0] c;
    (s_cmd_wr ##0 pwdata_i[14:11] == 4'h1, c = pwdata_i[7:0]) |-> ##2 tap_sel_o == (256'h1 << c);
  endproperty
  chk_ow_load: assert property (p_ow_load)
    else $error("overwrite write did not reach the tap");
  chk_sd_ladder: assert property (s_cmd_wr ##0 pwdata_i[14:13] == 2'h2 |->
    ##2 a_open_o && tap_sel_o == 256'h1 && seg_wb_o == 256'h0)
    else $error("shutdown did not open a and park the wiper");
  chk_tap_onehot: assert property (up_q == 3'h7 |-> $onehot(tap_sel_o))
    else $error("tap select not one-hot");
  chk_wb_steps: assert property (up_q == 3'h7 && !a_open_o |-> seg_wb_o == tap_sel_o - 256'h1)
    else $error("b segments disagree with tap");
  chk_wa_compl: assert property (up_q == 3'h7 |-> seg_wa_o == ~seg_wb_o)
    else $error("a segments not complement of b segments");
  chk_burn_len: assert property ($fell(fuse_blow_o) |-> burn_q == BURN_CYC)
    else $error("burn length wrong");
  chk_burn_hold: assert property (fuse_blow_o && blow_q |->
    $stable(fuse_blow_sel_o) && $stable(fuse_blow_data_o))
    else $error("burn target moved during burn");
  chk_blow_once: assert property ($rose(fuse_blow_o) |->
    !blown_q[fuse_blow_sel_o] && !(blown_q[1] && !fuse_blow_sel_o))
    else $error("array burnt a second time");
  chk_blow_start: assert property (s_cmd_wr ##0 pwdata_i[13] &&
    !blown_q[pwdata_i[15]] && !blown_q[1] |-> ##[1:2] fuse_blow_o)
    else $error("program command did not start a burn");
  chk_unmapped_err: assert property (psel_i && penable_i && paddr_i > `OTWP_ADDR_IMASK |-> pslverr_o)
    else $error("unmapped access not flagged");
endmodule // otwp_chk
bind otwp_top otwp_chk #(.BURN_CYC(BURN_CYC)) otwp_chk_inst (.core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pslverr_o(pslverr_o), .fuse_blow_o(fuse_blow_o),
  .fuse_blow_sel_o(fuse_blow_sel_o), .fuse_blow_data_o(fuse_blow_data_o),
  .tap_sel_o(tap_sel_o), .seg_wb_o(seg_wb_o), .seg_wa_o(seg_wa_o), .a_open_o(a_open_o));

// [dv/otwp_fuse_model.sv]
`timescale 1ns/1ps
// ======================================================
// fuse arrays: blank reads zero, a burn only sets bits
module otwp_fuse_model (
  // burn drive from the block
  input  logic       blow_i,
  input  logic       sel_i,
  input  logic [7:0] data_i,
  // fault injection: lowest bit is inverted on its way to the fuses
  input  logic       fail_i,
  // sensed state
  output logic       used0_o,
  output logic [7:0] val0_o,
  output logic       used1_o,
  output logic [7:0] val1_o
);
  // fuses are blank at first power-on, not at each reset
  initial begin
    {used0_o, val0_o, used1_o, val1_o} = 18'h0;
  end
  // commit at the end of the burn; a reburn can only add bits
  always @(negedge blow_i) begin
    if (sel_i) begin
      used1_o = 1'b1;
      val1_o = val1_o | (data_i ^ {7'h0, fail_i});
    end else begin
      used0_o = 1'b1;
      val0_o = val0_o | (data_i ^ {7'h0, fail_i});
    end
  end
endmodule // otwp_fuse_model

// [dv/otwp_top_tb_top.sv]
`timescale 1ns/1ps
`include "otwp_defines.vh"
// ======================================================
// bench: apb master, fuse model, ladder checks
module otwp_top_tb_top;
  logic           core_clk_i = 1'b0;
  logic           rst_n_i = 1'b0;
  logic           psel_i = 1'b0;
  logic           penable_i = 1'b0;
  logic           pwrite_i = 1'b0;
  logic [11:0]    paddr_i = 12'h0;
  logic [31:0]    pwdata_i = 32'h0;
  logic [31:0]    prdata_o, rd;          // read data and last taken word
  logic           pready_o, pslverr_o, irq_o, a_open_o, err;
  logic           u0, u1, blow, bsel;    // fuse sense and burn drive
  logic           fail_q = 1'b0;         // make the next burn go wrong
  logic [7:0]     v0, v1, bdat, lat;
  logic [255:0]   tap, wb, wa;
  logic [31:0]    rng = 32'hd0d67ec9;    // fixed seed
  int             err_count = 0;
  int             n_tests = 0;
  always #25 core_clk_i = ~core_clk_i;
  otwp_top #(.BURN_CYC(20)) otwp_top_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .fuse0_used_i(u0), .fuse0_val_i(v0), .fuse1_used_i(u1), .fuse1_val_i(v1),
    .fuse_blow_o(blow), .fuse_blow_sel_o(bsel), .fuse_blow_data_o(bdat),
    .tap_sel_o(tap), .seg_wb_o(wb), .seg_wa_o(wa), .a_open_o(a_open_o), .irq_o(irq_o));
  otwp_fuse_model otwp_fuse_model_inst (.blow_i(blow), .sel_i(bsel), .data_i(bdat),
    .fail_i(fail_q), .used0_o(u0), .val0_o(v0), .used1_o(u1), .val1_o(v1));
  // ======================================================
  // helpers
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic cmp_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_lad(input string nm, input logic [255:0] e, input logic [255:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, then an idle edge so psel never changes twice at one edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    @(posedge core_clk_i);
    // only the watchdog ends a wait for the answer
    while (pready_o !== 1'b1) @(posedge core_clk_i);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  // f = {array, shutdown, program, zero, overwrite}; ignored bits random
  task automatic wcmd(input logic [4:0] f, input logic [7:0] d);
    void'(rnd());
    apb(1'b1, `OTWP_ADDR_CMD, {16'h0, f, rng[10:8], d});
  endtask
  task automatic chk_cmd(input logic [1:0] v, input logic [7:0] l);
    apb(1'b0, `OTWP_ADDR_CMD, 32'h0);
    cmp_reg("cmd_read", {16'h0, v, 6'h0, l}, rd);
  endtask
  // ladder sampled mid-cycle, after the edge's updates have landed
  task automatic lad(input logic sd, input logic [7:0] l);
    logic [255:0] t;
    t = sd ? 256'h1 : 256'h1 << l;
    @(negedge core_clk_i);
    cmp_lad("tap_sel", t, tap);
    cmp_lad("seg_wb", t - 256'h1, wb);
    cmp_lad("seg_wa", ~(t - 256'h1), wa);
    cmp_reg("a_open", {31'h0, sd}, {31'h0, a_open_o});
    @(posedge core_clk_i);
  endtask
  task automatic istat(input logic [31:0] m);
    apb(1'b0, `OTWP_ADDR_ISTAT, 32'h0);
    cmp_reg("istat", m, rd & m);
    apb(1'b1, `OTWP_ADDR_ISTAT, 32'hf);
  endtask
  // burn takes 20 cycles plus sensing; a hang is left to the watchdog
  task automatic wait_idle();
    do begin
      apb(1'b0, `OTWP_ADDR_STATE, 32'h0);
    end while (rd[`OTWP_ST_BUSY] !== 1'b0);
  endtask
  task automatic power();
    rst_n_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
  endtask
  task automatic end_sim();
    $display("Checks %0d, errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ======================================================
  // watchdog: whole run needs well under 5000 cycles
  initial begin
    repeat (5000) @(posedge core_clk_i);
    err_count++;
    $display("Error watchdog expected done seen hang");
    end_sim();
  end
  // ======================================================
  // main sequence
  initial begin
    power();
    chk_cmd(2'h0, 8'h80);
    lad(1'b0, 8'h80);
    apb(1'b0, 12'h010, 32'h0);
    cmp_reg("unmapped_err", 32'h1, {31'h0, err});
    for (int i = 0; i < 8; i++) begin
      void'(rnd());
      lat = i == 0 ? 8'h00 : i == 1 ? 8'hff : rng[7:0];
      wcmd(5'h00, lat);
      lad(1'b0, lat);
      chk_cmd(2'h0, lat);
    end
    wcmd(5'h02, ~lat);
    chk_cmd(2'h0, lat);
    istat(32'h4);
    wcmd(5'h08, 8'h5a);
    lad(1'b1, 8'h5a);
    chk_cmd(2'h0, 8'h5a);
    wcmd(5'h00, 8'h5a);
    lad(1'b0, 8'h5a);
    wcmd(5'h04, 8'h00);
    wait_idle();
    chk_cmd(2'h3, 8'h5a);
    cmp_reg("fuse0", 32'h15a, {23'h0, u0, v0});
    cmp_reg("irq_masked", 32'h0, {31'h0, irq_o});
    apb(1'b1, `OTWP_ADDR_IMASK, 32'h1);
    cmp_reg("irq_on", 32'h1, {31'h0, irq_o});
    apb(1'b1, `OTWP_ADDR_ISTAT, 32'h1);
    cmp_reg("irq_clear", 32'h0, {31'h0, irq_o});
    apb(1'b1, `OTWP_ADDR_IMASK, 32'h0);
    wcmd(5'h04, 8'h00);
    // the sequencer refuses one edge after launch, status lands one edge later
    repeat (2) @(posedge core_clk_i);
    istat(32'h4);
    wcmd(5'h00, 8'h33);
    chk_cmd(2'h3, 8'h5a);
    for (int i = 0; i < 4; i++) begin
      void'(rnd());
      lat = rng[7:0];
      wcmd(5'h01, lat);
      lad(1'b0, lat);
    end
    wcmd(5'h00, 8'h77);
    chk_cmd(2'h3, 8'h5a);
    lad(1'b0, 8'h5a);
    power();
    chk_cmd(2'h3, 8'h5a);
    fail_q <= 1'b1;
    wcmd(5'h14, 8'h00);
    wait_idle();
    chk_cmd(2'h2, 8'h5a);
    istat(32'h2);
    fail_q <= 1'b0;
    power();
    chk_cmd(2'h3, 8'h5b);
    lad(1'b0, 8'h5b);
    end_sim();
  end
endmodule // otwp_top_tb_top
